/* shared/gpcd_pkg.sv */
package gpcd_pkg;

	//----------------------------------------
	// sizes
	//----------------------------------------
	localparam int PORT_W = 8;
	localparam int NIBBLE = 4;
	localparam int BUS_W  = 32;
	localparam int IDX_W  = 8;
	localparam int IDX_LSB = 2;

	//----------------------------------------
	// register indexes, byte address = index * 4
	//----------------------------------------
	localparam logic [IDX_W-1:0] IDX_LCD_DATA = 8'h02;
	localparam logic [IDX_W-1:0] IDX_SPI_DATA = 8'h03;
	localparam logic [IDX_W-1:0] IDX_LCD_DIR  = 8'h06;
	localparam logic [IDX_W-1:0] IDX_SPI_DIR  = 8'h07;
	localparam logic [IDX_W-1:0] IDX_ALT_CTRL = 8'h08;
	localparam logic [IDX_W-1:0] IDX_PIN_STAT = 8'h09;

	//----------------------------------------
	// field positions and reset values
	//----------------------------------------
	localparam int ALT_LCD_LO  = 0;
	localparam int ALT_LCD_HI  = 1;
	localparam int ALT_SPI_EN  = 2;
	localparam int ALT_KBD_LSB = 4;
	localparam logic [PORT_W-1:0] DIR_RESET = 8'h00;
	localparam logic [PORT_W-1:0] ALT_RESET = 8'h00;

	//----------------------------------------
	// ahb-lite encodings
	//----------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	//----------------------------------------
	// carriers
	//----------------------------------------
	typedef struct packed {
		logic [PORT_W-1:0] out;
		logic [PORT_W-1:0] oeN;
	} gpcd_pin_drive_t;

	typedef struct packed {
		logic [NIBBLE-1:0] out;
		logic [NIBBLE-1:0] oe;
	} gpcd_spi_drive_t;

endpackage

/* core/gpcd_sync2.sv */
`timescale 1ns/1ps
module gpcd_sync2
#(
	parameter int W = 8
)
(
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// level from outside the clock domain
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] stage1_r;
	logic [W-1:0] stage2_r;

	// stage1_r is read by stage2_r only
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			stage1_r <= '0;
			stage2_r <= '0;
		end
		else
		begin
			stage1_r <= din;
			stage2_r <= stage1_r;
		end
	end

	assign dout = stage2_r;

endmodule

/* core/gpcd_pin_mux.sv */
`timescale 1ns/1ps
module gpcd_pin_mux
(
	// clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	// port logic
	input  wire logic [gpcd_pkg::PORT_W-1:0]  latch,
	input  wire logic [gpcd_pkg::PORT_W-1:0]  dir,
	// alternate function takeover
	input  wire logic [gpcd_pkg::PORT_W-1:0]  altSel,
	input  wire logic [gpcd_pkg::PORT_W-1:0]  altOut,
	input  wire logic [gpcd_pkg::PORT_W-1:0]  altDrive,
	// pad drive
	output gpcd_pkg::gpcd_pin_drive_t         drive
);
	import gpcd_pkg::*;

	gpcd_pin_drive_t drive_r;
	gpcd_pin_drive_t drive_nxt;

	// alternate function overrides the port bit by bit
	always_comb
	begin
		drive_nxt.out = (altSel & altOut) | (~altSel & latch);
		drive_nxt.oeN = ~((altSel & altDrive) | (~altSel & dir));
	end

	// registered so pads never see decode glitches; out of reset all pins float
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			drive_r.out <= '0;
			drive_r.oeN <= '1;
		end
		else
			drive_r <= drive_nxt;
	end

	assign drive = drive_r;

endmodule

/* core/gpcd_ports.sv */
// Notes on behaviour
// RULE1: the lcd port keeps an eight-bit data latch that reset leaves untouched.
// RULE2: the spi/keyboard port keeps an eight-bit data latch that reset leaves untouched.
// RULE3: an lcd direction bit at one drives the pin, at zero the pin is an input.
// RULE4: a spi/keyboard direction bit at one drives the pin, at zero the pin is an input.
// RULE5: reset clears all lcd direction bits so every lcd pin starts as an input.
// RULE6: reset clears all spi/keyboard direction bits so every such pin starts as an input.
// RULE7: reading lcd data gives the latch for output bits and the pin level for input bits.
// RULE8: reading spi/keyboard data gives the latch for outputs and the pin for inputs.
// RULE9: writes to either data register always load the latch whatever the direction.
// RULE10: writing an input pin's data bit changes only the latch, not the pin or its readback.
// RULE11: both direction registers read back exactly what was written.
// RULE12: software should load data before turning a pin from input to output.
// RULE13: two nibble enables hand the lcd port halves to the frontplane outputs.
// RULE14: the spi enable hands bits 0 to 3 of the spi/keyboard port to the spi pins.
// RULE15: per-pin keyboard enables turn bits 4 to 7 of that port into keyboard inputs.
// RULE16: where the spi/keyboard pins are unbonded, software should make all of them outputs.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module gpcd_ports
(
	// clock and reset
	input  wire logic                             sys_clk,
	input  wire logic                             rst,
	// ahb-lite slave
	input  wire logic                             hsel,
	input  wire logic [gpcd_pkg::BUS_W-1:0]       haddr,
	input  wire logic [1:0]                       htrans,
	input  wire logic                             hwrite,
	input  wire logic [2:0]                       hsize,
	input  wire logic [gpcd_pkg::BUS_W-1:0]       hwdata,
	input  wire logic                             hready,
	output logic      [gpcd_pkg::BUS_W-1:0]       hrdata,
	output logic                                  hreadyout,
	output logic                                  hresp,
	// lcd-shared port
	input  wire logic [gpcd_pkg::PORT_W-1:0]      lcdPinIn,
	output gpcd_pkg::gpcd_pin_drive_t             lcdPinDrive,
	input  wire logic [gpcd_pkg::PORT_W-1:0]      lcdFrontplaneOutputs,
	// spi/keyboard-shared port
	input  wire logic [gpcd_pkg::PORT_W-1:0]      spiKbdPinIn,
	output gpcd_pkg::gpcd_pin_drive_t             spiKbdPinDrive,
	input  gpcd_pkg::gpcd_spi_drive_t             spiDrive,
	output logic      [gpcd_pkg::NIBBLE-1:0]      spiPinLevel,
	output logic      [gpcd_pkg::NIBBLE-1:0]      keyboardIrqInputs
);
	import gpcd_pkg::*;

	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RDWAIT, BUS_RDDONE} gpcd_bus_state_t;

	//----------------------------------------
	// decode helpers
	//----------------------------------------
	function automatic logic addrHit(input logic [BUS_W-1:0] a, input logic [2:0] sz);
		logic [IDX_W-1:0] idx;
		idx = a[IDX_LSB +: IDX_W];
		addrHit = (sz == HSIZE_WORD) && (a[IDX_LSB-1:0] == '0)
			&& (a[BUS_W-1:IDX_LSB+IDX_W] == '0)
			&& (idx == IDX_LCD_DATA || idx == IDX_SPI_DATA || idx == IDX_LCD_DIR
			|| idx == IDX_SPI_DIR || idx == IDX_ALT_CTRL || idx == IDX_PIN_STAT);
	endfunction

	function automatic logic [PORT_W-1:0] portRead(input logic [PORT_W-1:0] latch,
		input logic [PORT_W-1:0] dir, input logic [PORT_W-1:0] pin);
		portRead = (latch & dir) | (pin & ~dir);
	endfunction

	//----------------------------------------
	// state
	//----------------------------------------
	gpcd_bus_state_t   state_r;
	logic [IDX_W-1:0]  addrIdx_r;
	logic              addrOk_r;
	logic [BUS_W-1:0]  hrdata_r;
	logic [BUS_W-1:0]  rd_nxt;
	logic              hreadyout_r;
	logic [PORT_W-1:0] lcdLatch_r;
	logic [PORT_W-1:0] spiKbdLatch_r;
	logic [PORT_W-1:0] lcdDir_r;
	logic [PORT_W-1:0] spiKbdDir_r;
	logic [PORT_W-1:0] altCtrl_r;
	logic [NIBBLE-1:0] spiPinLevel_r;
	logic [NIBBLE-1:0] kbdLevel_r;
	logic [PORT_W-1:0] lcdPinLevel;
	logic [PORT_W-1:0] spiKbdPinLevel;
	logic [PORT_W-1:0] lcdAltSel;
	logic [PORT_W-1:0] spiKbdAltSel;
	logic [NIBBLE-1:0] kbdEn;
	logic              accept;
	logic              wrPhase;
	logic              wrLcdData;
	logic              wrSpiData;
	logic              wrLcdDir;
	logic              wrSpiDir;
	logic              wrAlt;

	//----------------------------------------
	// ahb-lite slave
	//----------------------------------------
	assign accept  = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign wrPhase = (state_r == BUS_WRITE) && addrOk_r;
	assign wrLcdData = wrPhase && (addrIdx_r == IDX_LCD_DATA);
	assign wrSpiData = wrPhase && (addrIdx_r == IDX_SPI_DATA);
	assign wrLcdDir  = wrPhase && (addrIdx_r == IDX_LCD_DIR);
	assign wrSpiDir  = wrPhase && (addrIdx_r == IDX_SPI_DIR);
	assign wrAlt     = wrPhase && (addrIdx_r == IDX_ALT_CTRL);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state_r <= BUS_IDLE;
		else
			case (state_r)
			BUS_RDWAIT: state_r <= BUS_RDDONE;
			default:
				if (accept)
					state_r <= hwrite ? BUS_WRITE : BUS_RDWAIT;
				else
					state_r <= BUS_IDLE;
			endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			addrIdx_r <= '0;
			addrOk_r  <= 1'b0;
		end
		else if (accept)
		begin
			addrIdx_r <= haddr[IDX_LSB +: IDX_W];
			addrOk_r  <= addrHit(haddr, hsize);
		end
	end

	// one wait state on reads so a write just before is always seen
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			hreadyout_r <= 1'b1;
		else if (state_r == BUS_RDWAIT)
			hreadyout_r <= 1'b1;
		else if (accept && !hwrite)
			hreadyout_r <= 1'b0;
	end

	always_comb
	begin
		rd_nxt = '0;
		if (addrOk_r)
			case (addrIdx_r)
			IDX_LCD_DATA: rd_nxt[PORT_W-1:0] = portRead(lcdLatch_r, lcdDir_r, lcdPinLevel); // [RULE7]
			IDX_SPI_DATA: rd_nxt[PORT_W-1:0] = portRead(spiKbdLatch_r, spiKbdDir_r, spiKbdPinLevel); // [RULE8]
			IDX_LCD_DIR:  rd_nxt[PORT_W-1:0] = lcdDir_r; // [RULE11]
			IDX_SPI_DIR:  rd_nxt[PORT_W-1:0] = spiKbdDir_r; // [RULE11]
			IDX_ALT_CTRL: rd_nxt[PORT_W-1:0] = altCtrl_r;
			IDX_PIN_STAT: rd_nxt[2*PORT_W-1:0] = {spiKbdPinLevel, lcdPinLevel};
			default:      rd_nxt = '0;
			endcase
	end

	// unmapped or non-word reads return zero
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			hrdata_r <= '0;
		else if (state_r == BUS_RDWAIT)
			hrdata_r <= rd_nxt;
		else
			hrdata_r <= '0;
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp     = HRESP_OKAY;

	//----------------------------------------
	// port registers
	//----------------------------------------
	// latches carry no reset: their contents survive it
	always_ff @(posedge sys_clk)
	begin
		if (wrLcdData)
			lcdLatch_r <= hwdata[PORT_W-1:0]; // [RULE1] [RULE9] [RULE10]
	end

	always_ff @(posedge sys_clk)
	begin
		if (wrSpiData)
			spiKbdLatch_r <= hwdata[PORT_W-1:0]; // [RULE2] [RULE9] [RULE10]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			lcdDir_r <= DIR_RESET; // [RULE5]
		else if (wrLcdDir)
			lcdDir_r <= hwdata[PORT_W-1:0]; // [RULE11]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			spiKbdDir_r <= DIR_RESET; // [RULE6]
		else if (wrSpiDir)
			spiKbdDir_r <= hwdata[PORT_W-1:0]; // [RULE11]
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			altCtrl_r <= ALT_RESET;
		else if (wrAlt)
			altCtrl_r <= hwdata[PORT_W-1:0];
	end

	//----------------------------------------
	// pins
	//----------------------------------------
	gpcd_sync2 #(.W(PORT_W)) u_lcd_sync
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     (lcdPinIn),
		.dout    (lcdPinLevel)
	);

	gpcd_sync2 #(.W(PORT_W)) u_spi_kbd_sync
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     (spiKbdPinIn),
		.dout    (spiKbdPinLevel)
	);

	assign kbdEn = altCtrl_r[ALT_KBD_LSB +: NIBBLE];
	assign lcdAltSel = {{NIBBLE{altCtrl_r[ALT_LCD_HI]}}, {NIBBLE{altCtrl_r[ALT_LCD_LO]}}}; // [RULE13]
	assign spiKbdAltSel = {kbdEn, {NIBBLE{altCtrl_r[ALT_SPI_EN]}}}; // [RULE14] [RULE15]

	gpcd_pin_mux u_lcd_mux
	(
		.sys_clk  (sys_clk),
		.rst      (rst),
		.latch    (lcdLatch_r),
		.dir      (lcdDir_r), // [RULE3]
		.altSel   (lcdAltSel),
		.altOut   (lcdFrontplaneOutputs),
		.altDrive ({PORT_W{1'b1}}),
		.drive    (lcdPinDrive)
	);

	// keyboard pins are inputs only, so their drive is forced off
	gpcd_pin_mux u_spi_kbd_mux
	(
		.sys_clk  (sys_clk),
		.rst      (rst),
		.latch    (spiKbdLatch_r),
		.dir      (spiKbdDir_r), // [RULE4]
		.altSel   (spiKbdAltSel),
		.altOut   ({{NIBBLE{1'b0}}, spiDrive.out}),
		.altDrive ({{NIBBLE{1'b0}}, spiDrive.oe}), // [RULE15]
		.drive    (spiKbdPinDrive)
	);

	// disabled keyboard lines idle high, like a pulled-up key
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			spiPinLevel_r <= '0;
			kbdLevel_r    <= '1;
		end
		else
		begin
			spiPinLevel_r <= spiKbdPinLevel[NIBBLE-1:0];
			kbdLevel_r    <= spiKbdPinLevel[PORT_W-1:NIBBLE] | ~kbdEn;
		end
	end

	assign spiPinLevel       = spiPinLevel_r;
	assign keyboardIrqInputs = kbdLevel_r;

	//----------------------------------------
	// assertions
	//----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_lcd_latch_keep;
		@(posedge sys_clk) disable iff (1'b0)
		rst |=> lcdLatch_r === $past(lcdLatch_r);
	endproperty
	a_lcd_latch_keep: assert property (p_lcd_latch_keep) else $error("lcd latch hit by reset"); // [RULE1]
	property p_spi_latch_keep;
		@(posedge sys_clk) disable iff (1'b0)
		rst |=> spiKbdLatch_r === $past(spiKbdLatch_r);
	endproperty
	a_spi_latch_keep: assert property (p_spi_latch_keep) else $error("spi latch hit by reset"); // [RULE2]

	property p_lcd_oe;
		(lcdAltSel == '0) |=> lcdPinDrive.oeN == ~$past(lcdDir_r);
	endproperty
	a_lcd_oe: assert property (p_lcd_oe) else $error("lcd drive differs from direction"); // [RULE3]
	property p_spi_oe;
		(spiKbdAltSel == '0) |=> spiKbdPinDrive.oeN == ~$past(spiKbdDir_r);
	endproperty
	a_spi_oe: assert property (p_spi_oe) else $error("spi port drive differs from direction"); // [RULE4]

	property p_lcd_dir_rst;
		$past(rst) |-> lcdDir_r == DIR_RESET ##1 lcdPinDrive.oeN == '1;
	endproperty
	a_lcd_dir_rst: assert property (p_lcd_dir_rst) else $error("lcd direction not cleared"); // [RULE5]
	property p_spi_dir_rst;
		$past(rst) |-> spiKbdDir_r == DIR_RESET;
	endproperty
	a_spi_dir_rst: assert property (p_spi_dir_rst) else $error("spi direction not cleared"); // [RULE6]

	property p_lcd_read;
		(state_r == BUS_RDWAIT && addrOk_r && addrIdx_r == IDX_LCD_DATA) |=> hreadyout
			&& hrdata[PORT_W-1:0] == (($past(lcdLatch_r) & $past(lcdDir_r))
			| ($past(lcdPinLevel) & ~$past(lcdDir_r)));
	endproperty
	a_lcd_read: assert property (p_lcd_read) else $error("lcd data read wrong"); // [RULE7]
	property p_spi_read;
		(state_r == BUS_RDWAIT && addrOk_r && addrIdx_r == IDX_SPI_DATA) |=> hreadyout
			&& hrdata[PORT_W-1:0] == (($past(spiKbdLatch_r) & $past(spiKbdDir_r))
			| ($past(spiKbdPinLevel) & ~$past(spiKbdDir_r)));
	endproperty
	a_spi_read: assert property (p_spi_read) else $error("spi data read wrong"); // [RULE8]

	property p_latch_write;
		wrLcdData |=> lcdLatch_r == $past(hwdata[PORT_W-1:0]);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch write lost"); // [RULE9]
	property p_input_write;
		(wrSpiData && spiKbdDir_r == '0 && spiKbdAltSel == '0) ##1 (spiKbdDir_r == '0
			&& spiKbdAltSel == '0) |=> spiKbdPinDrive.oeN == '1;
	endproperty
	a_input_write: assert property (p_input_write) else $error("input pin driven by write"); // [RULE10]

	property p_dir_readback;
		wrLcdDir ##1 (accept && !hwrite && haddr[IDX_LSB +: IDX_W] == IDX_LCD_DIR
			&& addrHit(haddr, hsize) && !wrLcdDir) |-> ##2 hrdata[PORT_W-1:0] == $past(lcdDir_r);
	endproperty
	a_dir_readback: assert property (p_dir_readback) else $error("direction readback wrong"); // [RULE11]

	property p_lcd_fp;
		altCtrl_r[ALT_LCD_HI] |=> lcdPinDrive.oeN[PORT_W-1:NIBBLE] == '0
			&& lcdPinDrive.out[PORT_W-1:NIBBLE] == $past(lcdFrontplaneOutputs[PORT_W-1:NIBBLE]);
	endproperty
	a_lcd_fp: assert property (p_lcd_fp) else $error("frontplane not on upper pins"); // [RULE13]
	property p_spi_take;
		altCtrl_r[ALT_SPI_EN] |=> spiKbdPinDrive.out[NIBBLE-1:0] == $past(spiDrive.out)
			&& spiKbdPinDrive.oeN[NIBBLE-1:0] == ~$past(spiDrive.oe);
	endproperty
	a_spi_take: assert property (p_spi_take) else $error("spi pins not taken over"); // [RULE14]
	property p_kbd_input;
		1'b1 |=> (spiKbdPinDrive.oeN[PORT_W-1:NIBBLE] & $past(kbdEn)) == $past(kbdEn);
	endproperty
	a_kbd_input: assert property (p_kbd_input) else $error("keyboard pin driven"); // [RULE15]

	c_lcd_read: cover property (state_r == BUS_RDWAIT && addrIdx_r == IDX_LCD_DATA);
	c_dir_write: cover property (wrSpiDir ##1 spiKbdDir_r != DIR_RESET);
	c_spi_on: cover property (altCtrl_r[ALT_SPI_EN] && spiKbdDir_r == '0);
	c_read_back: cover property (wrSpiData ##[1:3] state_r == BUS_RDDONE);

endmodule

/* tb/gpcd_pad_model.sv */
`timescale 1ns/1ps
module gpcd_pad_model
	import gpcd_pkg::*;
(
	// pad drive from the port
	input  gpcd_pkg::gpcd_pin_drive_t        drive,
	// level the outside circuit puts on a released pad
	input  wire logic [gpcd_pkg::PORT_W-1:0] extLevel,
	// resolved pad level
	output logic      [gpcd_pkg::PORT_W-1:0] padLevel
);
	//----------------------------------------
	// pad resolution
	//----------------------------------------
	// a driven pad follows the port, a released one follows the outside circuit
	always_comb
	begin
		for (int i = 0; i < PORT_W; i++)
			padLevel[i] = drive.oeN[i] ? extLevel[i] : drive.out[i];
	end
endmodule

/* tb/gpcd_ports_bench.sv */
`timescale 1ns/1ps
module gpcd_ports_bench;
	import gpcd_pkg::*;

	//----------------------------------------
	// signals
	//----------------------------------------
	localparam logic [31:0] A_LCD_D = 32'(IDX_LCD_DATA) << IDX_LSB;
	localparam logic [31:0] A_SPI_D = 32'(IDX_SPI_DATA) << IDX_LSB;
	localparam logic [31:0] A_LCD_R = 32'(IDX_LCD_DIR) << IDX_LSB;
	localparam logic [31:0] A_SPI_R = 32'(IDX_SPI_DIR) << IDX_LSB;
	localparam logic [31:0] A_ALT   = 32'(IDX_ALT_CTRL) << IDX_LSB;
	localparam logic [31:0] A_STAT  = 32'(IDX_PIN_STAT) << IDX_LSB;
	localparam logic [7:0]  LCD_EXT = 8'h3C;
	localparam logic [7:0]  SPI_EXT = 8'h96;
	localparam int          LIMIT   = 5000;
	logic                   sys_clk;
	logic                   rst;
	logic                   hsel;
	logic [31:0]            haddr;
	logic [1:0]             htrans;
	logic                   hwrite;
	logic [2:0]             hsize;
	logic [31:0]            hwdata;
	logic [31:0]            hrdata;
	logic                   hreadyout;
	logic                   hresp;
	logic [7:0]             lcdPad;
	logic [7:0]             spiPad;
	logic [7:0]             frontplane;
	gpcd_pin_drive_t        lcdDrive;
	gpcd_pin_drive_t        spiKbdDrive;
	gpcd_spi_drive_t        spiDrv;
	logic [3:0]             spiLevel;
	logic [3:0]             kbdLevel;
	int                     err_total;
	int                     comparisons;
	int                     cycles;

	//----------------------------------------
	// instances
	//----------------------------------------
	gpcd_ports i_gpcd_ports (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lcdPinIn(lcdPad),
		.lcdPinDrive(lcdDrive), .lcdFrontplaneOutputs(frontplane), .spiKbdPinIn(spiPad),
		.spiKbdPinDrive(spiKbdDrive), .spiDrive(spiDrv), .spiPinLevel(spiLevel),
		.keyboardIrqInputs(kbdLevel));
	gpcd_pad_model i_gpcd_pad_model_lcd (.drive(lcdDrive), .extLevel(LCD_EXT), .padLevel(lcdPad));
	gpcd_pad_model i_gpcd_pad_model_spi (.drive(spiKbdDrive), .extLevel(SPI_EXT),
		.padLevel(spiPad));

	//----------------------------------------
	// clock and timeout
	//----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			err_total++;
			conclude();
		end
	end

	//----------------------------------------
	// tasks
	//----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chkReg(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chkPin(input string nm, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// the address phase is held until hready is seen high, the data phase likewise
	task automatic ahbXfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wdata;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rdata = hrdata;
		chkReg("hresp", 32'(HRESP_OKAY), 32'(hresp));
	endtask

	task automatic wr(input logic [31:0] addr, input logic [7:0] data);
		logic [31:0] unused;
		ahbXfer(1'b1, addr, {24'h0, data}, unused);
	endtask

	task automatic rdChk(input string nm, input logic [31:0] addr, input logic [31:0] exp);
		logic [31:0] got;
		ahbXfer(1'b0, addr, 32'h0, got);
		chkReg(nm, exp, got);
	endtask

	// drive follows a register one edge late, reads see pads through two sync stages
	task automatic settle();
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic doReset();
		rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
	endtask

	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial
	begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		frontplane = 8'hC3;
		spiDrv = '{out: 4'hE, oe: 4'h6};
		err_total = 0;
		comparisons = 0;
		cycles = 0;
		doReset();
		rdChk("lcd dir reset", A_LCD_R, 32'h0);
		rdChk("spi dir reset", A_SPI_R, 32'h0);
		rdChk("alt reset", A_ALT, 32'h0);
		rdChk("unmapped", 32'h40, 32'h0);
		chkPin("lcd oeN reset", 8'hFF, lcdDrive.oeN);
		chkPin("spi oeN reset", 8'hFF, spiKbdDrive.oeN);
		// data first, then direction, so no stale value reaches the pads
		wr(A_LCD_D, 8'hA5);
		wr(A_SPI_D, 8'h5A);
		settle();
		rdChk("lcd data input", A_LCD_D, {24'h0, LCD_EXT});
		rdChk("spi data input", A_SPI_D, {24'h0, SPI_EXT});
		rdChk("pin status", A_STAT, {16'h0, SPI_EXT, LCD_EXT});
		wr(A_LCD_R, 8'h0F);
		wr(A_SPI_R, 8'hF0);
		settle();
		rdChk("lcd data mixed", A_LCD_D, 32'h35);
		rdChk("spi data mixed", A_SPI_D, 32'h56);
		rdChk("lcd dir", A_LCD_R, 32'h0F);
		rdChk("spi dir", A_SPI_R, 32'hF0);
		chkPin("lcd oeN", 8'hF0, lcdDrive.oeN);
		chkPin("lcd out", 8'h05, lcdDrive.out & 8'h0F);
		chkPin("spi oeN", 8'h0F, spiKbdDrive.oeN);
		chkPin("spi out", 8'h50, spiKbdDrive.out & 8'hF0);
		doReset();
		rdChk("lcd dir rerst", A_LCD_R, 32'h0);
		rdChk("spi dir rerst", A_SPI_R, 32'h0);
		wr(A_LCD_R, 8'hFF);
		rdChk("lcd dir all", A_LCD_R, 32'hFF);
		// misaligned address is refused, so the direction must not move
		wr(A_LCD_R + 32'h1, 8'h00);
		rdChk("lcd dir kept", A_LCD_R, 32'hFF);
		wr(A_SPI_R, 8'hFF);
		settle();
		rdChk("lcd latch kept", A_LCD_D, 32'hA5);
		rdChk("spi latch kept", A_SPI_D, 32'h5A);
		wr(A_ALT, 8'h01);
		settle();
		chkPin("fp low", 8'hA3, lcdDrive.out);
		wr(A_ALT, 8'h02);
		settle();
		chkPin("fp high", 8'hC5, lcdDrive.out);
		wr(A_ALT, 8'h04);
		settle();
		chkPin("spi oeN alt", 8'h09, spiKbdDrive.oeN);
		chkPin("spi out alt", 8'h56, spiKbdDrive.out & 8'hF6);
		chkPin("spi level", 8'h06, {4'h0, spiLevel});
		wr(A_ALT, 8'hF0);
		settle();
		chkPin("kbd oeN all", 8'hF0, spiKbdDrive.oeN);
		chkPin("kbd level all", 8'h09, {4'h0, kbdLevel});
		wr(A_ALT, 8'h50);
		settle();
		chkPin("kbd oeN part", 8'h50, spiKbdDrive.oeN);
		chkPin("kbd level part", 8'h0B, {4'h0, kbdLevel});
		rdChk("alt readback", A_ALT, 32'h50);
		conclude();
	end
endmodule
